/* File: design/fcp_config_port.sv */
// configuration pin controller: clear/wait sequencing and data ports
// assumes async pins; two-way pins split into out and oe_n, low drives
// How it works
// - mode pins sampled before configuration pick the configuration mode
// - after configuration mode pins 0,2 pass in, pin 1 drives out
// - without boundary scan, scan output becomes unregistered user output
// - without boundary scan, scan functions stop and scan inputs go user
// - high-active busy flag driven high until configuration completes
// - low-active busy flag driven low until configuration completes
// - clear status line pulled low during power-up and memory clearing
// - external low on clear status line holds device in wait
// - master modes wait an extra 30 to 300 us after line rises
// - configuration data error drives clear status line low
// - peripheral select needs low-active select low, high-active high
// - selected write strobe low loads data byte into buffer
// - selected read strobe drives bit 7 ready status, others low
// - both strobes low: write acts, read ignored
// - master parallel drives 18 prom address outputs, released after
// - parallel modes take bytes on data inputs, serial pin as bit 0
// - serial modes sample serial input on configuration clock rise
// - chain output repeats data on fall 1.5 clock periods later
// - unused outputs stay high impedance with pull-up before and during
// - configuration clock driven in master and async peripheral modes
// - reprogram release: finish clear, one more clear, then wait
// - master parallel: read clock rises before each address change
`include "fcp_regs.svh"

module fcp_config_port
    import fcp_pkg::*;
#(
    parameter int WAIT_CYC = `FCP_WAIT_CYC,
    parameter int CLEAR_CYC = `FCP_CLEAR_CYC,
    parameter int PWR_CYC = `FCP_PWR_CYC,
    parameter int CONFIG_CLOCK_HALF = `FCP_CONFIG_CLOCK_HALF
)
(
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic reprogram_n, // reprogram pin, low clears
    input wire logic mode_pin_0, // mode pin 0
    input wire logic mode_pin_1, // mode pin 1
    input wire logic mode_pin_2, // mode pin 2
    output logic mode_pin_1_out, // mode pin 1 output
    output logic mode_pin_1_oe_n, // mode pin 1 enable
    output logic user_mode_0, // mode pin 0 to user logic
    output logic user_mode_2, // mode pin 2 to user logic
    input wire logic user_m1_out, // user value for mode pin 1
    input wire logic user_m1_oe_n, // user enable for mode pin 1
    input wire logic scan_used, // boundary scan option chosen
    output logic scan_fn_en, // boundary scan logic enabled
    output logic scan_pins_user, // scan inputs released to user
    input wire logic user_tdo, // user value for scan output
    input wire logic user_tdo_oe_n, // user enable for scan output
    input wire logic scan_tdo, // scan chain serial output
    output logic tdo_out, // scan output pin value
    output logic tdo_oe_n, // scan output pin enable
    output logic cfg_active_high_flag, // high during configuration
    output logic cfg_active_high_oe_n, // enable of that flag
    output logic cfg_active_low_flag, // low during configuration
    output logic cfg_active_low_oe_n, // enable of that flag
    input wire logic init_in, // clear status line level
    output logic init_out, // clear status drive value
    output logic init_oe_n, // clear status pull-down enable
    input wire logic chip_select_low_n, // select, active low
    input wire logic chip_select_high, // select, active high
    input wire logic write_strobe_n, // write strobe, active low
    input wire logic read_strobe_n, // read strobe, active low
    input wire logic [7:1] cfg_byte_in, // data bits 7..1
    input wire logic din, // serial data, bit 0 in parallel
    output logic [7:0] cfg_byte_out, // status read value
    output logic cfg_byte_oe_n, // status read enable
    output logic [17:0] prom_addr, // prom address
    output logic prom_addr_oe_n, // prom address enable
    output logic rclk_out, // redundant read clock
    output logic rclk_oe_n, // read clock enable
    input wire logic config_clock_in, // configuration clock pin in
    output logic config_clock_out, // configuration clock drive
    output logic config_clock_oe_n, // configuration clock enable
    output logic dout, // daisy chain data
    output logic dout_oe_n, // daisy chain enable
    output logic rdy_busy, // high when a byte may be written
    output logic cfg_bit, // configuration data bit
    output logic cfg_bit_valid, // one-cycle strobe for cfg_bit
    input wire logic cfg_error, // data checker found an error
    input wire logic cfg_complete, // data checker saw the end
    output logic cfg_done // configuration has completed
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NS = 18;
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_reg;
    logic [NS-1:0] s2_reg;

    assign raw = {reprogram_n, init_in, config_clock_in, din,
        write_strobe_n, read_strobe_n, chip_select_low_n,
        chip_select_high, mode_pin_2, mode_pin_1, mode_pin_0,
        cfg_byte_in};

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++)
        begin : g_sync
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    s1_reg[gi] <= 1'b1;
                    s2_reg[gi] <= 1'b1;
                end
                else
                begin
                    s1_reg[gi] <= raw[gi];
                    s2_reg[gi] <= s1_reg[gi];
                end
            end
        end
    endgenerate

    logic prog_s, init_s, config_clock_s, din_s, ws_s, rs_s, cs0_s, cs1_s;
    logic [2:0] mode_s;
    logic [7:0] byte_s;
    assign {prog_s, init_s, config_clock_s, din_s, ws_s, rs_s, cs0_s, cs1_s,
        mode_s} = s2_reg[17:7];
    assign byte_s = {s2_reg[6:0], din_s};

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    fcp_state_t state_reg;
    fcp_mode_t mode_reg;
    logic [31:0] cnt_reg;
    logic extra_reg;
    logic err_reg;
    logic in_cfg;
    logic master;
    logic serial;
    logic par;
    logic periph;
    logic config_clock_drv;

    assign in_cfg = (state_reg == FCP_CFG);
    assign master = (mode_reg == `FCP_MODE_MSER) ||
        (mode_reg == `FCP_MODE_MPAR_UP) ||
        (mode_reg == `FCP_MODE_MPAR_DN);
    assign serial = (mode_reg == `FCP_MODE_MSER) ||
        (mode_reg == `FCP_MODE_SLAVE);
    assign par = (mode_reg == `FCP_MODE_MPAR_UP) ||
        (mode_reg == `FCP_MODE_MPAR_DN);
    assign periph = (mode_reg == `FCP_MODE_PSYNC) ||
        (mode_reg == `FCP_MODE_PASYNC);
    assign config_clock_drv = master || (mode_reg == `FCP_MODE_PASYNC);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= FCP_PWR;
            cnt_reg <= 32'h0;
            extra_reg <= 1'b0;
        end
        else if (state_reg != FCP_PWR && !prog_s &&
            state_reg != FCP_CLR)
        begin
            state_reg <= FCP_CLR;
            cnt_reg <= 32'h0;
            extra_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                FCP_PWR:
                begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg == 32'(PWR_CYC - 1))
                    begin
                        state_reg <= FCP_CLR;
                        cnt_reg <= 32'h0;
                    end
                end
                FCP_CLR:
                begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (!prog_s)
                        extra_reg <= 1'b0;
                    if (cnt_reg == 32'(CLEAR_CYC - 1))
                    begin
                        cnt_reg <= 32'h0;
                        if (prog_s && !extra_reg)
                            extra_reg <= 1'b1;
                        else if (prog_s)
                            state_reg <= FCP_WAIT;
                    end
                end
                FCP_WAIT:
                begin
                    cnt_reg <= 32'h0;
                    if (init_s)
                        state_reg <= master ? FCP_DLY : FCP_CFG;
                end
                FCP_DLY:
                begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (!init_s)
                        state_reg <= FCP_WAIT;
                    else if (cnt_reg == 32'(WAIT_CYC - 1))
                        state_reg <= FCP_CFG;
                end
                FCP_CFG:
                begin
                    if (cfg_complete && !err_reg)
                        state_reg <= FCP_DONE;
                end
                FCP_DONE: ;
            endcase
        end
    end

    // mode caught once, at the end of the last clear cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            mode_reg <= `FCP_MODE_MSER;
        else if (state_reg == FCP_CLR && prog_s && extra_reg &&
            cnt_reg == 32'(CLEAR_CYC - 1))
            mode_reg <= mode_s;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            err_reg <= 1'b0;
        else if (state_reg == FCP_CLR)
            err_reg <= 1'b0;
        else if (in_cfg && cfg_error)
            err_reg <= 1'b1;
    end

    // ------------------------------------------------------------
    // configuration clock
    // ------------------------------------------------------------
    logic [15:0] div_reg;
    logic config_clock_int_reg;
    logic config_clock_prev_reg;
    logic config_clock_now;
    logic cc_rise;
    logic cc_fall;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_reg <= 16'h0;
            config_clock_int_reg <= 1'b0;
        end
        else if (!in_cfg || !config_clock_drv)
        begin
            div_reg <= 16'h0;
            config_clock_int_reg <= 1'b0;
        end
        else if (div_reg == 16'(CONFIG_CLOCK_HALF - 1))
        begin
            div_reg <= 16'h0;
            config_clock_int_reg <= !config_clock_int_reg;
        end
        else
            div_reg <= div_reg + 16'h1;
    end

    // both sources go through the same edge finder
    assign config_clock_now = config_clock_drv ? config_clock_int_reg : config_clock_s;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            config_clock_prev_reg <= 1'b0;
        else
            config_clock_prev_reg <= config_clock_now;
    end

    assign cc_rise = in_cfg && config_clock_now && !config_clock_prev_reg;
    assign cc_fall = in_cfg && !config_clock_now && config_clock_prev_reg;

    // ------------------------------------------------------------
    // peripheral byte port
    // ------------------------------------------------------------
    logic sel;
    logic ws_prev_reg;
    logic buf_full_reg;
    logic [7:0] buf_reg;
    logic drain;

    assign sel = !cs0_s && cs1_s;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ws_prev_reg <= 1'b1;
        else
            ws_prev_reg <= ws_s;
    end

    // a write while busy is dropped; the host must poll ready first
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            buf_full_reg <= 1'b0;
            buf_reg <= 8'h0;
        end
        else if (!in_cfg)
            buf_full_reg <= 1'b0;
        else if (periph && sel && !ws_s && ws_prev_reg &&
            !buf_full_reg)
        begin
            buf_reg <= byte_s;
            buf_full_reg <= 1'b1;
        end
        else if (drain)
            buf_full_reg <= 1'b0;
    end

    assign rdy_busy = !buf_full_reg;
    // write strobe low masks the read
    assign cfg_byte_oe_n = !(in_cfg && periph && sel && !rs_s &&
        ws_s);
    assign cfg_byte_out = {!buf_full_reg, 7'h00};

    // ------------------------------------------------------------
    // data path and prom addressing
    // ------------------------------------------------------------
    logic [6:0] sh_reg;
    logic [2:0] sh_cnt_reg;
    logic bit_v;
    logic bit_d;
    logic adv_reg;
    logic load_par;

    assign load_par = par && sh_cnt_reg == 3'h0;
    assign drain = cc_rise && periph && sh_cnt_reg == 3'h0 &&
        buf_full_reg;

    always_comb
    begin
        bit_v = 1'b0;
        bit_d = 1'b0;
        if (cc_rise && serial)
        begin
            bit_v = 1'b1;
            bit_d = din_s;
        end
        else if (cc_rise && sh_cnt_reg != 3'h0)
        begin
            bit_v = 1'b1;
            bit_d = sh_reg[0];
        end
        else if (cc_rise && load_par)
        begin
            bit_v = 1'b1;
            bit_d = byte_s[0];
        end
        else if (drain)
        begin
            bit_v = 1'b1;
            bit_d = buf_reg[0];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sh_reg <= 7'h0;
            sh_cnt_reg <= 3'h0;
        end
        else if (!in_cfg)
            sh_cnt_reg <= 3'h0;
        else if (cc_rise && sh_cnt_reg != 3'h0)
        begin
            sh_reg <= {1'b0, sh_reg[6:1]};
            sh_cnt_reg <= sh_cnt_reg - 3'h1;
        end
        else if ((cc_rise && load_par) || drain)
        begin
            sh_reg <= load_par ? byte_s[7:1] : buf_reg[7:1];
            sh_cnt_reg <= 3'h7;
        end
    end

    // address moves on the fall after the byte is taken
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prom_addr <= `FCP_ADDR_RST;
            rclk_out <= 1'b0;
            adv_reg <= 1'b0;
        end
        else if (state_reg == FCP_CLR)
        begin
            prom_addr <= (mode_s == `FCP_MODE_MPAR_DN) ?
                ~`FCP_ADDR_RST : `FCP_ADDR_RST;
            rclk_out <= 1'b0;
            adv_reg <= 1'b0;
        end
        else if (cc_rise && load_par)
        begin
            rclk_out <= 1'b1;
            adv_reg <= 1'b1;
        end
        else if (cc_fall && adv_reg)
        begin
            rclk_out <= 1'b0;
            adv_reg <= 1'b0;
            prom_addr <= (mode_reg == `FCP_MODE_MPAR_DN) ?
                prom_addr - 18'h1 : prom_addr + 18'h1;
        end
    end

    // ------------------------------------------------------------
    // daisy chain output
    // ------------------------------------------------------------
    logic st1_reg, st1v_reg, st2_reg, st2v_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st1_reg <= 1'b1;
            st1v_reg <= 1'b0;
            st2_reg <= 1'b1;
            st2v_reg <= 1'b0;
            dout <= 1'b1;
        end
        else if (cc_rise)
        begin
            st1_reg <= bit_d;
            st1v_reg <= bit_v;
            st2_reg <= st1_reg;
            st2v_reg <= st1v_reg;
        end
        else if (cc_fall && st2v_reg)
            dout <= st2_reg;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_bit <= 1'b0;
            cfg_bit_valid <= 1'b0;
        end
        else
        begin
            cfg_bit <= bit_d;
            cfg_bit_valid <= bit_v;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    assign cfg_done = (state_reg == FCP_DONE);
    assign cfg_active_high_flag = 1'b1;
    assign cfg_active_high_oe_n = cfg_done;
    assign cfg_active_low_flag = 1'b0;
    assign cfg_active_low_oe_n = cfg_done;
    assign init_out = 1'b0;
    assign init_oe_n = !(state_reg == FCP_PWR ||
        state_reg == FCP_CLR || err_reg);
    // pins below float with a pull-up unless their mode uses them
    assign prom_addr_oe_n = !(in_cfg && par);
    assign rclk_oe_n = !(in_cfg && par);
    assign config_clock_out = config_clock_int_reg;
    assign config_clock_oe_n = !(in_cfg && config_clock_drv);
    assign dout_oe_n = !in_cfg;
    // user paths are unregistered by design
    assign user_mode_0 = cfg_done & mode_pin_0;
    assign user_mode_2 = cfg_done & mode_pin_2;
    assign mode_pin_1_out = user_m1_out;
    assign mode_pin_1_oe_n = !cfg_done | user_m1_oe_n;
    assign scan_fn_en = !cfg_done || scan_used;
    assign scan_pins_user = cfg_done && !scan_used;
    assign tdo_out = (cfg_done && !scan_used) ? user_tdo : scan_tdo;
    assign tdo_oe_n = (cfg_done && !scan_used) ? user_tdo_oe_n :
        !scan_used;

endmodule

/* File: design/fcp_regs.svh */
// constants for the configuration pin controller
// assumes a 200 MHz system clock
`ifndef FCP_REGS_SVH
`define FCP_REGS_SVH

// mode pin codes, {mode_pin_2, mode_pin_1, mode_pin_0}
`define FCP_MODE_MSER 3'h0
`define FCP_MODE_PSYNC 3'h3
`define FCP_MODE_MPAR_UP 3'h4
`define FCP_MODE_PASYNC 3'h5
`define FCP_MODE_MPAR_DN 3'h6
`define FCP_MODE_SLAVE 3'h7

// master wait after the clear status line rises, least value
`define FCP_CLK_MHZ 200
`define FCP_WAIT_US 30
`define FCP_WAIT_CYC (`FCP_WAIT_US * `FCP_CLK_MHZ)

`define FCP_PWR_CYC 64
`define FCP_CLEAR_CYC 256
`define FCP_CONFIG_CLOCK_HALF 8
`define FCP_ADDR_RST 18'h00000

`endif

/* File: design/fcp_pkg.sv */
// types shared by the configuration pin controller
// assumes fcp_regs.svh for the numeric constants
package fcp_pkg;
    typedef enum logic [2:0] {
        FCP_PWR,
        FCP_CLR,
        FCP_WAIT,
        FCP_DLY,
        FCP_CFG,
        FCP_DONE
    } fcp_state_t;
    typedef logic [2:0] fcp_mode_t;
endpackage

/* File: verif/fcp_prom_model.sv */
// configuration prom model driving the parallel data pins
// assumes the device drives prom_addr only while prom_addr_oe_n is low
module fcp_prom_model (
    input wire logic [17:0] addr, // address from the device
    input wire logic oe_n, // address enable, low while driven
    output logic [7:0] data // byte back to the data pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // released: inverse of the byte, so a lost enable shows
    assign data = (addr[7:0] ^ 8'h3c) ^ {8{oe_n}};
endmodule

/* File: verif/fcp_port_monitor.sv */
// port checker for the configuration pin controller
// assumes it is bound onto fcp_config_port, clk domain only
module fcp_port_monitor #(
    parameter int WAIT_CYC = 8
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic reprogram_n, init_in, init_out, init_oe_n, // clear
    input wire logic mode_pin_0, mode_pin_2, user_mode_0, user_mode_2, // mode
    input wire logic mode_pin_1_out, mode_pin_1_oe_n, // mode pin 1
    input wire logic user_m1_out, user_m1_oe_n, // user mode pin 1
    input wire logic scan_used, scan_fn_en, scan_pins_user, // scan
    input wire logic user_tdo, user_tdo_oe_n, tdo_out, tdo_oe_n, // tdo
    input wire logic cfg_active_high_flag, cfg_active_high_oe_n, // flag
    input wire logic cfg_active_low_flag, cfg_active_low_oe_n, // flag
    input wire logic write_strobe_n, cfg_byte_oe_n, rdy_busy, // port
    input wire logic [7:0] cfg_byte_out, // status byte
    input wire logic [17:0] prom_addr, // prom address
    input wire logic prom_addr_oe_n, rclk_out, rclk_oe_n, // prom
    input wire logic config_clock_oe_n, dout_oe_n, // clock, chain
    input wire logic cfg_error, cfg_done // checker and done
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // cycles the clear status line has stood high, saturating
    int hi_cnt;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            hi_cnt <= 0;
        else if (!init_in)
            hi_cnt <= 0;
        else if (hi_cnt < WAIT_CYC + 8)
            hi_cnt <= hi_cnt + 1;
    end
    a_flag_high: assert property (
        cfg_active_high_oe_n == cfg_done && cfg_active_high_flag
        && cfg_active_low_oe_n == cfg_done && !cfg_active_low_flag)
        else $error("busy flag wrong");
    a_clear_pull: assert property (
        (!reprogram_n)[*5] |-> !init_oe_n && !init_out)
        else $error("clear line not pulled");
    a_wait_hold: assert property (
        (dout_oe_n && !init_in)[*4] |=> dout_oe_n)
        else $error("started while line low");
    a_master_wait: assert property (
        $fell(prom_addr_oe_n) |-> hi_cnt >= WAIT_CYC)
        else $error("master wait too short");
    a_error_pull: assert property (
        cfg_error && !dout_oe_n |-> ##[1:3] !init_oe_n)
        else $error("error not shown");
    a_addr_rclk: assert property (
        !prom_addr_oe_n && $changed(prom_addr) |-> $past(rclk_out))
        else $error("address moved without read clock");
    a_status_read: assert property (
        !cfg_byte_oe_n |-> cfg_byte_out == {rdy_busy, 7'h00})
        else $error("status byte wrong");
    a_write_wins: assert property (
        (!write_strobe_n)[*4] |-> cfg_byte_oe_n)
        else $error("read drove during write");
    a_user_pins: assert property (
        cfg_done |-> user_mode_0 == mode_pin_0 && user_mode_2 == mode_pin_2
        && mode_pin_1_oe_n == user_m1_oe_n && mode_pin_1_out == user_m1_out)
        else $error("mode pins not user");
    a_scan_user: assert property (
        cfg_done && !scan_used |-> !scan_fn_en && scan_pins_user
        && tdo_out == user_tdo && tdo_oe_n == user_tdo_oe_n)
        else $error("scan pins not user");
    a_idle_hiz: assert property (
        dout_oe_n |-> prom_addr_oe_n && rclk_oe_n && config_clock_oe_n
        && cfg_byte_oe_n)
        else $error("output driven outside configuration");
    c_master: cover property ($fell(prom_addr_oe_n));
    c_status: cover property (!cfg_byte_oe_n);
    c_error: cover property (!init_oe_n && !dout_oe_n);
endmodule

bind fcp_config_port fcp_port_monitor #(.WAIT_CYC(WAIT_CYC)) u_mon (.*);

/* File: verif/tb_fcp_config_port.sv */
// self-checking bench for the configuration pin controller
// assumes the prom model and port checker are compiled with it
`include "fcp_regs.svh"
module tb_fcp_config_port
    import fcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WAIT_CYC = 8;
    logic clk, rstn, prog_n, ext_low, sclk, scan_used, cfg_error;
    logic cfg_complete, cs_n, cs_hi, ws_n, rs_n, host_din, d0, cck_in;
    logic init_in, init_out, init_oe_n, cfg_byte_oe_n, prom_addr_oe_n;
    logic config_clock_out, config_clock_oe_n, dout, dout_oe_n;
    logic rdy_busy, cfg_bit, cfg_bit_valid, cfg_done, ck, pa;
    logic [7:1] host_byte, d_hi;
    logic [7:0] cfg_byte_out, prom_data, st;
    logic [17:0] prom_addr;
    logic [4:0] usr;
    fcp_mode_t mode;
    fcp_mode_t modes[6] = '{`FCP_MODE_MSER, `FCP_MODE_PSYNC,
        `FCP_MODE_MPAR_UP, `FCP_MODE_PASYNC, `FCP_MODE_MPAR_DN,
        `FCP_MODE_SLAVE};
    logic bq[$];
    int n_fail = 0;
    int n_compared = 0;
    int i, k;
    // open-drain clear line with pull-up
    assign init_in = (init_oe_n | init_out) & ~ext_low;
    assign cck_in = config_clock_oe_n ? sclk : config_clock_out;
    assign {d_hi, d0} = prom_addr_oe_n ? {host_byte, host_din} : prom_data;
    fcp_prom_model u_prom (.addr(prom_addr), .oe_n(prom_addr_oe_n),
        .data(prom_data));
    fcp_config_port #(.WAIT_CYC(WAIT_CYC), .CLEAR_CYC(4), .PWR_CYC(4),
        .CONFIG_CLOCK_HALF(2)) DUT (
        .clk, .rstn, .reprogram_n(prog_n),
        .mode_pin_0(mode[0]), .mode_pin_1(mode[1]), .mode_pin_2(mode[2]),
        .mode_pin_1_out(), .mode_pin_1_oe_n(), .user_mode_0(),
        .user_mode_2(), .user_m1_out(usr[0]), .user_m1_oe_n(usr[1]),
        .scan_used, .scan_fn_en(), .scan_pins_user(),
        .user_tdo(usr[2]), .user_tdo_oe_n(usr[3]), .scan_tdo(usr[4]),
        .tdo_out(), .tdo_oe_n(), .cfg_active_high_flag(),
        .cfg_active_high_oe_n(), .cfg_active_low_flag(),
        .cfg_active_low_oe_n(), .init_in, .init_out, .init_oe_n,
        .chip_select_low_n(cs_n), .chip_select_high(cs_hi),
        .write_strobe_n(ws_n), .read_strobe_n(rs_n), .cfg_byte_in(d_hi),
        .din(d0), .cfg_byte_out, .cfg_byte_oe_n, .prom_addr,
        .prom_addr_oe_n, .rclk_out(), .rclk_oe_n(),
        .config_clock_in(cck_in), .config_clock_out, .config_clock_oe_n,
        .dout, .dout_oe_n, .rdy_busy, .cfg_bit, .cfg_bit_valid,
        .cfg_error, .cfg_complete, .cfg_done);
    initial
    begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (cfg_bit_valid === 1'b1)
            bq.push_back(cfg_bit);
    end
    task automatic wrap_up();
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hang(input int k, lim);
        if (k >= lim)
        begin
            chk(18'h1, 18'h0);
            wrap_up();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk_bits(input logic [15:0] e);
        for (int j = 0; j < 16; j++)
            chk(bq[j], e[j]);
    endtask
    // clear, latch mode m, hold clear line low, then start
    task automatic start(input fcp_mode_t m);
        int k;
        ext_low = 1;
        prog_n = 0;
        mode = m;
        tick(6);
        chk(init_oe_n, 0);
        prog_n = 1;
        for (k = 0; k < 300 && init_oe_n !== 1; k++)
            tick(1);
        hang(k, 300);
        tick(40);
        chk(dout_oe_n, 1);
        bq.delete();
        ext_low = 0;
        for (k = 0; k < 300 && dout_oe_n !== 0; k++)
            tick(1);
        hang(k, 300);
        if (m == 3'h0 || m == 3'h4 || m == 3'h6)
            chk(k >= WAIT_CYC, 1);
    endtask
    // slave link clock, 25 system cycles a period, still between frames
    task automatic sbits(input logic [15:0] v);
        for (int j = 0; j < 16; j++)
        begin
            host_din = v[j];
            tick(12);
            if (j >= 2)
                chk(dout, v[j-2]);
            sclk = 1;
            tick(13);
            sclk = 0;
        end
        host_din = ~v[15];
    endtask
    task automatic host(input logic hi, w, r, input logic [7:0] b);
        int k;
        for (k = 0; k < 400 && w && rdy_busy !== 1; k++)
            tick(1);
        hang(k, 400);
        {cs_n, cs_hi, ws_n, rs_n} = {1'b0, hi, ~w, ~r};
        {host_byte, host_din} = b;
        tick(4);
        st = cfg_byte_oe_n === 1'b0 ? cfg_byte_out : 8'hff;
        {cs_n, cs_hi, ws_n, rs_n} = 4'hb;
        {host_byte, host_din} = ~b;
        tick(2);
    endtask
    initial
    begin
        {rstn, prog_n, ext_low, sclk, cfg_error, cfg_complete} = 6'h10;
        {cs_n, cs_hi, ws_n, rs_n, host_byte, host_din} = {4'hb, 8'h00};
        mode = 3'h0;
        usr = 5'h0a;
        scan_used = 0;
        tick(20);
        rstn = 1;
        for (i = 0; i < 6; i++)
        begin
            scan_used = i[0];
            usr = 5'h0a ^ 5'(i);
            start(modes[i]);
            ck = modes[i] == 3'h3 || modes[i] == 3'h7;
            pa = !(modes[i] == 3'h4 || modes[i] == 3'h6);
            chk(config_clock_oe_n, ck);
            chk(prom_addr_oe_n, pa);
            chk(prom_addr, modes[i] == 3'h6 ? 18'h3ffff : 18'h0);
            mode = ~mode;
            tick(6);
            chk(config_clock_oe_n, ck);
            cfg_complete = 1;
            tick(3);
            cfg_complete = 0;
            chk(cfg_done, 1);
            chk(prom_addr_oe_n, 1);
        end
        start(`FCP_MODE_MPAR_UP);
        for (k = 0; k < 400 && bq.size() < 16; k++)
            tick(1);
        hang(k, 400);
        chk(prom_addr, 18'h2);
        chk_bits({8'h3d, 8'h3c});
        start(`FCP_MODE_SLAVE);
        sbits(16'hc5a3);
        chk(18'(bq.size()), 16);
        chk_bits(16'hc5a3);
        cfg_error = 1;
        tick(3);
        chk(init_oe_n, 0);
        cfg_error = 0;
        start(`FCP_MODE_PASYNC);
        host(1, 1, 0, 8'h96);
        host(1, 1, 1, 8'h4b);
        chk(st, 8'hff);
        host(1, 0, 1, 8'h00);
        chk(st, 8'h00);
        for (k = 0; k < 400 && rdy_busy !== 1; k++)
            tick(1);
        hang(k, 400);
        host(1, 0, 1, 8'h00);
        chk(st, 8'h80);
        host(0, 1, 0, 8'he1);
        tick(80);
        chk(18'(bq.size()), 16);
        chk_bits({8'h4b, 8'h96});
        wrap_up();
    end
endmodule
